// ==== rtl/rtcb_defines.vh ====
/*
  constants for the timekeeper serial access block: command byte layout,
  register locations, charger field layout, reset values and link phases.
  assumes it is included by its bare name from the design files under rtl/.
*/
`ifndef RTCB_DEFINES_VH
`define RTCB_DEFINES_VH

// ==========================================================
// command byte fields
`define RTCB_CMD_VALID_BIT 7
`define RTCB_CMD_RAM_BIT 6
`define RTCB_CMD_LOC_HI 5
`define RTCB_CMD_LOC_LO 1
`define RTCB_CMD_READ_BIT 0
`define RTCB_LOC_BURST 5'h1F

// ==========================================================
// clock space locations (charger location is chosen, not documented)
`define RTCB_LOC_CONTROL 5'h07
`define RTCB_LOC_CHARGER 5'h08
`define RTCB_CLK_LAST 5'h07
`define RTCB_RAM_LAST 5'h1E
`define RTCB_TIME_BYTES 7

// ==========================================================
// control register
`define RTCB_WP_BIT 7
`define RTCB_WP_RST 1'b1

// ==========================================================
// charger configuration fields
`define RTCB_CHG_UNLOCK_HI 7
`define RTCB_CHG_UNLOCK_LO 4
`define RTCB_CHG_DIODE_HI 3
`define RTCB_CHG_DIODE_LO 2
`define RTCB_CHG_RES_HI 1
`define RTCB_CHG_RES_LO 0
`define RTCB_CHG_UNLOCK_KEY 4'hA
`define RTCB_DIODE_ONE 2'h1
`define RTCB_DIODE_TWO 2'h2
`define RTCB_RES_NONE 2'h0
`define RTCB_CHG_RST 8'h00

// ==========================================================
// link phases
`define RTCB_PH_CMD 2'h0
`define RTCB_PH_DATA 2'h1
`define RTCB_PH_IDLE 2'h2

`endif

// ==== rtl/rtcb_sync.v ====
/*
  two flip-flop synchroniser for a group of independent levels.
  assumes each bit is a level from outside the sys_clk domain; bits are not
  coherent with each other after the crossing.
*/
`timescale 1ns/1ps

module rtcb_sync #(
  parameter W = 1
) (
  input wire sys_clk, // block clock
  input wire rstn, // asynchronous reset, active low
  input wire [W-1:0] async_in, // levels from outside the domain
  output wire [W-1:0] sync_out // levels safe to use in sys_clk domain
);

  reg [W-1:0] meta_q; // first stage, read only by second stage
  reg [W-1:0] sync_q; // second stage

  // ==========================================================
  // two stages
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ==== rtl/rtcb_top.v ====
/*
  serial access block of a timekeeper: three-wire link (transfer enable,
  shift clock, two-way data), single and burst access to the clock/calendar
  bytes, control byte and 31-byte scratch ram, single access to the charger configuration.
  assumes the timekeeping counter sits outside on sys_clk, presents its time
  on core_time and accepts byte-masked loads on the core_wr_* port; the link
  pins come from another domain and are sampled by sys_clk.

*/
`timescale 1ns/1ps
`include "rtcb_defines.vh"

module rtcb_top (
  input wire sys_clk, // 20 MHz block clock
  input wire rstn, // asynchronous reset, active low
  input wire link_ce, // transfer enable pin, high during a transfer
  input wire link_sclk, // shift clock pin from host
  input wire link_dio_in, // data pin as seen at the pad
  output wire link_dio_out, // data driven onto the pin
  output wire link_dio_oe, // high while the block drives the data pin
  input wire [55:0] core_time, // running time, byte i at bits 8i+7..8i
  output reg core_wr_en, // one-cycle load strobe to the time counter
  output reg [6:0] core_wr_mask, // which time bytes to load
  output reg [55:0] core_wr_data, // time bytes to load, same layout
  output wire write_protect, // current write-protect flag
  output wire charger_enable, // charger path switched on
  output wire charger_two_diodes, // two diodes in series when enabled
  output wire [1:0] charger_resistor // 0 none, 1 low, 2 mid, 3 high
);

  // ==========================================================
  // pin synchronisers
  wire [2:0] pins_s; // synchronised {data, shift clock, enable}
  wire ce_s; // enable after crossing
  wire sclk_s; // shift clock after crossing
  wire dio_s; // data after crossing

  rtcb_sync #(
    .W(3)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in({link_dio_in, link_sclk, link_ce}),
    .sync_out(pins_s)
  );

  assign ce_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign dio_s = pins_s[2];

  // ==========================================================
  // state
  reg sclk_p_q; // shift clock one cycle ago, for edge finding
  reg [1:0] phase_q; // command, data or ignoring
  reg [2:0] bit_q; // bit position within the current byte
  reg [7:0] in_sh_q; // incoming shift register
  reg [7:0] cmd_q; // accepted command byte
  reg [4:0] idx_q; // current location within the space
  reg [7:0] out_sh_q; // outgoing shift register
  reg dout_q; // bit on the data pin
  reg oe_q; // data pin drive enable
  reg [55:0] snap_q; // time copy taken at each read command
  reg [55:0] stage_q; // clock burst write bytes awaiting commit
  reg wp_q; // write-protect flag
  reg wp_burst_q; // write-protect seen when the command completed
  reg [7:0] chg_q; // charger configuration
  reg [7:0] ram [0:30]; // scratch ram, 31 locations

  // ==========================================================
  // edges and byte decode
  wire rise; // shift clock rising inside a transfer
  wire fall; // shift clock falling inside a transfer
  wire [7:0] byte_in; // byte complete with the bit sampled now
  wire in_cmd; // currently taking the command byte
  wire cur_ram; // command selects ram space
  wire cur_rd; // command is a read
  wire cur_burst; // command addresses location 31
  wire [4:0] last_idx; // last location of the burst space
  wire [4:0] nxt_idx; // location after the current one
  wire byte_done; // last bit of a byte sampled now

  assign rise = ce_s & sclk_s & ~sclk_p_q;
  assign fall = ce_s & ~sclk_s & sclk_p_q;
  assign byte_in = {dio_s, in_sh_q[7:1]};
  assign in_cmd = (phase_q == `RTCB_PH_CMD);
  assign cur_ram = cmd_q[`RTCB_CMD_RAM_BIT];
  assign cur_rd = cmd_q[`RTCB_CMD_READ_BIT];
  assign cur_burst = (cmd_q[`RTCB_CMD_LOC_HI:`RTCB_CMD_LOC_LO] == `RTCB_LOC_BURST);
  // clock bursts wrap after the control byte, so the charger stays out of reach
  assign last_idx = cur_ram ? `RTCB_RAM_LAST : `RTCB_CLK_LAST;
  assign nxt_idx = (idx_q == last_idx) ? 5'h00 : idx_q + 5'h01;
  assign byte_done = rise & (bit_q == 3'h7);

  // the byte to present: at command completion it follows the command being
  // latched and live time, afterwards the stored command and the time copy
  wire [4:0] new_loc; // location field of the arriving command
  wire mux_ram; // space of the byte to fetch
  wire [4:0] mux_idx; // location of the byte to fetch
  wire [55:0] mux_time; // time source for the fetch
  reg [7:0] rd_byte; // fetched byte

  assign new_loc = byte_in[`RTCB_CMD_LOC_HI:`RTCB_CMD_LOC_LO];
  assign mux_ram = in_cmd ? byte_in[`RTCB_CMD_RAM_BIT] : cur_ram;
  assign mux_idx = in_cmd ? ((new_loc == `RTCB_LOC_BURST) ? 5'h00 : new_loc) :
    ((cur_burst) ? nxt_idx : idx_q);
  assign mux_time = in_cmd ? core_time : snap_q;

  // ==========================================================
  // read data selection
  always @* begin
    rd_byte = 8'h00;
    if (mux_ram) begin
      if (mux_idx <= `RTCB_RAM_LAST) begin
        rd_byte = ram[mux_idx];
      end
    end else if (mux_idx < `RTCB_LOC_CONTROL) begin
      rd_byte = mux_time[{mux_idx[2:0], 3'b000} +: 8];
    end else if (mux_idx == `RTCB_LOC_CONTROL) begin
      rd_byte = {wp_q, 7'h00}; // low control bits read as zero
    end else if (mux_idx == `RTCB_LOC_CHARGER) begin
      rd_byte = chg_q;
    end
  end

  // ==========================================================
  // write decode for the byte that completes now
  wire wr_done; // write data byte complete
  wire ram_we; // store into scratch ram
  wire clk_single; // single write to a clock location
  wire [6:0] single_mask; // byte lane of a single time write

  assign wr_done = byte_done & (phase_q == `RTCB_PH_DATA) & ~cur_rd;
  assign ram_we = wr_done & cur_ram & ~wp_q & (idx_q <= `RTCB_RAM_LAST);
  assign clk_single = wr_done & ~cur_ram & ~cur_burst;
  assign single_mask = 7'h01 << idx_q[2:0];

  // ==========================================================
  // scratch ram storage, no reset: contents are undefined at power-up
  always @(posedge sys_clk) begin
    if (ram_we) begin
      ram[idx_q] <= byte_in;
    end
  end

  // ==========================================================
  // link engine
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_p_q <= 1'b0;
      phase_q <= `RTCB_PH_CMD;
      bit_q <= 3'h0;
      in_sh_q <= 8'h00;
      cmd_q <= 8'h00;
      idx_q <= 5'h00;
      out_sh_q <= 8'h00;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      snap_q <= 56'h00_0000_0000_0000;
      stage_q <= 56'h00_0000_0000_0000;
      wp_q <= `RTCB_WP_RST;
      wp_burst_q <= 1'b0;
      chg_q <= `RTCB_CHG_RST;
      core_wr_en <= 1'b0;
      core_wr_mask <= 7'h00;
      core_wr_data <= 56'h00_0000_0000_0000;
    end else begin
      sclk_p_q <= sclk_s;
      core_wr_en <= 1'b0;
      if (!ce_s) begin
        // enable low ends any transfer and releases the pin; a clock burst
        // write cut short here is simply dropped
        phase_q <= `RTCB_PH_CMD;
        bit_q <= 3'h0;
        oe_q <= 1'b0;
      end else if (rise) begin
        // every rising edge samples and releases the pin
        oe_q <= 1'b0;
        bit_q <= bit_q + 3'h1;
        in_sh_q <= byte_in;
        case (phase_q)
          `RTCB_PH_CMD: begin
            if (bit_q == 3'h7) begin
              cmd_q <= byte_in;
              idx_q <= mux_idx;
              snap_q <= core_time;
              wp_burst_q <= wp_q;
              out_sh_q <= rd_byte;
              // a cleared top bit makes the whole transfer void
              if (byte_in[`RTCB_CMD_VALID_BIT]) begin
                phase_q <= `RTCB_PH_DATA;
              end else begin
                phase_q <= `RTCB_PH_IDLE;
              end
            end
          end
          `RTCB_PH_DATA: begin
            if (bit_q == 3'h7) begin
              if (cur_rd) begin
                // single reads repeat the byte, bursts step and wrap
                idx_q <= mux_idx;
                out_sh_q <= rd_byte;
              end else if (!cur_burst) begin
                // single write: one byte, extra clocks ignored
                phase_q <= `RTCB_PH_IDLE;
                if (!cur_ram) begin
                  if (idx_q == `RTCB_LOC_CONTROL) begin
                    wp_q <= byte_in[`RTCB_WP_BIT];
                  end else if (idx_q == `RTCB_LOC_CHARGER) begin
                    if (!wp_q) begin
                      chg_q <= byte_in;
                    end
                  end else if ((idx_q < `RTCB_LOC_CONTROL) && !wp_q) begin
                    core_wr_en <= clk_single;
                    core_wr_mask <= single_mask;
                    core_wr_data <= {`RTCB_TIME_BYTES{byte_in}};
                  end
                end
              end else if (cur_ram) begin
                // ram burst: each byte lands as it completes
                idx_q <= nxt_idx;
                if (idx_q == `RTCB_RAM_LAST) begin
                  phase_q <= `RTCB_PH_IDLE;
                end
              end else begin
                // clock burst: all eight bytes or nothing
                idx_q <= nxt_idx;
                if (idx_q < `RTCB_LOC_CONTROL) begin
                  stage_q[{idx_q[2:0], 3'b000} +: 8] <= byte_in;
                end else begin
                  phase_q <= `RTCB_PH_IDLE;
                  if (!wp_burst_q) begin
                    wp_q <= byte_in[`RTCB_WP_BIT];
                    core_wr_en <= 1'b1;
                    core_wr_mask <= 7'h7F;
                    core_wr_data <= stage_q;
                  end
                end
              end
            end
          end
          `RTCB_PH_IDLE: begin
            bit_q <= 3'h0; // ignore the rest of the transfer
          end
          default: begin
            phase_q <= `RTCB_PH_IDLE;
          end
        endcase
      end else if (fall && (phase_q == `RTCB_PH_DATA) && cur_rd) begin
        // read data goes out after each falling edge, lsb first
        dout_q <= out_sh_q[0];
        oe_q <= 1'b1;
        out_sh_q <= {1'b0, out_sh_q[7:1]};
      end
    end
  end

  assign link_dio_out = dout_q;
  assign link_dio_oe = oe_q;
  assign write_protect = wp_q;

  // ==========================================================
  // charger decode
  wire [3:0] chg_unlock; // unlock field
  wire [1:0] chg_diode; // diode count select
  wire [1:0] chg_res; // resistor select
  wire chg_on_d; // decoded enable, next value of chg_on_q
  reg chg_on_q; // charger path switched on
  reg chg_two_q; // two diodes in series
  reg [1:0] chg_res_q; // resistor handed to the switch

  assign chg_unlock = chg_q[`RTCB_CHG_UNLOCK_HI:`RTCB_CHG_UNLOCK_LO];
  assign chg_diode = chg_q[`RTCB_CHG_DIODE_HI:`RTCB_CHG_DIODE_LO];
  assign chg_res = chg_q[`RTCB_CHG_RES_HI:`RTCB_CHG_RES_LO];
  // every field must agree before the path closes, guarding against a
  // stray write switching current into the backup supply
  assign chg_on_d = (chg_unlock == `RTCB_CHG_UNLOCK_KEY) &&
    ((chg_diode == `RTCB_DIODE_ONE) || (chg_diode == `RTCB_DIODE_TWO)) &&
    (chg_res != `RTCB_RES_NONE);

  // ==========================================================
  // charger outputs: registered so the analog switches never see a decode
  // glitch; costs one cycle after a write, far below any frame time
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // switched off until a configuration byte arrives
      chg_on_q <= 1'b0;
      chg_two_q <= 1'b0;
      chg_res_q <= `RTCB_RES_NONE;
    end else begin
      chg_on_q <= chg_on_d;
      chg_two_q <= chg_on_d && (chg_diode == `RTCB_DIODE_TWO);
      chg_res_q <= chg_on_d ? chg_res : `RTCB_RES_NONE;
    end
  end

  assign charger_enable = chg_on_q;
  assign charger_two_diodes = chg_two_q;
  assign charger_resistor = chg_res_q;

endmodule

// ==== sim/rtcb_checker.sv ====
/*
  assertions on the top ports of the serial access block.
  assumes a bind from the testbench top file, all names matching the ports.
*/
`timescale 1ns/1ps
module rtcb_checker (
  input wire sys_clk, // block clock
  input wire rstn, // reset, active low
  input wire link_sclk, // shift clock pin
  input wire link_dio_oe, // data pin enable
  input wire core_wr_en, // time load strobe
  input wire [6:0] core_wr_mask, // load lanes
  input wire write_protect, // protect flag
  input wire charger_enable, // charger on
  input wire charger_two_diodes, // two diodes
  input wire [1:0] charger_resistor // resistor pick
);
  // ====================
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_res_when_on: assert property (charger_enable |-> charger_resistor != 2'h0)
    else $error("charger on with no resistor");
  a_diode_needs_on: assert property (charger_two_diodes |-> charger_enable)
    else $error("two diodes while charger off");
  a_chg_rst_off: assert property ($rose(rstn) |-> !charger_enable)
    else $error("charger on after reset");
  a_wp_rst_set: assert property ($rose(rstn) |-> write_protect)
    else $error("protect clear after reset");
  a_load_one_cycle: assert property (core_wr_en |=> !core_wr_en)
    else $error("load strobe longer than a cycle");
  a_load_unprot: assert property (core_wr_en |-> !$past(write_protect))
    else $error("time load while protected");
  a_load_lanes: assert property (core_wr_en |->
    core_wr_mask == 7'h7F || $onehot(core_wr_mask))
    else $error("load lanes neither all nor one");
  a_pin_rel_rise: assert property ($rose(link_sclk) |-> ##[1:6] !link_dio_oe)
    else $error("data pin held after clock rise");
  // charger settings may only move through an unprotected write
  a_chg_wp_hold: assert property (write_protect && $past(write_protect) |->
    $stable({charger_enable, charger_resistor}))
    else $error("charger changed while protected");
endmodule

// ==== sim/rtcb_host_model.sv ====
/*
  host model for the three-wire link: enable, shift clock, data pin.
  assumes the bench resolves the pin from both enables, pull-down otherwise.
*/
`timescale 1ns/1ps
module rtcb_host_model (
  output logic ce, // transfer enable
  output logic sclk, // shift clock, idle low
  output logic hd, // bit driven by host
  output logic hoe, // host drives data pin
  input wire dio // resolved pin level
);
  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    hd = 1'b0;
    hoe = 1'b0;
  end
  // odd delay keeps link edges off the block clock phase
  task automatic open_frame();
    #1013 ce = 1'b1;
    #1000;
  endtask
  // one byte out, lsb first, stable across each rise
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      hoe = 1'b1;
      hd = b[i];
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    // pin stays driven until a read or the frame end releases it, so two
    // bytes in a row never toggle the enable within one time step
  endtask
  // one byte in, taken just after each rise while still driven
  task automatic get(output logic [7:0] b);
    hoe = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #200 sclk = 1'b1;
      #20 b[i] = dio;
      #180 sclk = 1'b0;
    end
  endtask
  // enable stays high until the last byte has moved
  task automatic close_frame();
    hoe = 1'b0;
    #200 ce = 1'b0;
    #1200;
  endtask
endmodule

// ==== sim/tb_top.sv ====
/*
  testbench: charger decode, write protect, single and burst access.
  assumes rtcb_top, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rstn, ce, sclk, hd, hoe, dout, doe, wen, wp, cen, ctwo;
  logic [1:0] cres;
  logic [6:0] wmask, lmask;
  logic [55:0] ctime, wdata, ldata;
  logic [55:0] tm = 56'h1122_3344_5566_77;
  logic [7:0] rb, mem [0:30], rd [0:8];
  logic [7:0] cv [0:9] = '{8'hA5, 8'hA9, 8'hAB, 8'hA6, 8'hA1, 8'hAD, 8'hA4, 8'h55, 8'hB5, 8'h00};
  wire dio;
  int fail_count = 0;
  int check_count = 0;
  int wr_cnt = 0;
  // pin level: block, then host, else the pull-down
  assign dio = doe ? dout : (hoe ? hd : 1'b0);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  rtcb_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .link_ce(ce), .link_sclk(sclk),
    .link_dio_in(dio), .link_dio_out(dout), .link_dio_oe(doe), .core_time(ctime),
    .core_wr_en(wen), .core_wr_mask(wmask), .core_wr_data(wdata), .write_protect(wp),
    .charger_enable(cen), .charger_two_diodes(ctwo), .charger_resistor(cres));
  rtcb_host_model i_host (.ce(ce), .sclk(sclk), .hd(hd), .hoe(hoe), .dio(dio));
  // count time loads and keep the last one
  always @(posedge sys_clk) begin
    if (wen === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      lmask <= wmask;
      ldata <= wdata;
    end
  end
  // ====================
  // helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr1(input logic [7:0] c, input logic [7:0] d);
    i_host.open_frame();
    i_host.put(c);
    i_host.put(d);
    i_host.close_frame();
  endtask
  task automatic rd1(input logic [7:0] c, output logic [7:0] b);
    i_host.open_frame();
    i_host.put(c);
    i_host.get(b);
    i_host.close_frame();
  endtask
  // clock burst write: seven time bytes, then control
  task automatic cburst(input logic [63:0] v);
    i_host.open_frame();
    i_host.put(8'hBE);
    for (int i = 0; i < 8; i++)
      i_host.put(v[8*i+:8]);
    i_host.close_frame();
  endtask
  // enable, two-diode flag and resistor expected for a charger byte
  function automatic logic [3:0] chg_exp(input logic [7:0] v);
    if (v[7:4] == 4'hA && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0)
      return {1'b1, v[3:2] == 2'h2, v[1:0]};
    return 4'h0;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    conclude();
  end
  // ====================
  // main sequence
  initial begin
    rstn = 1'b0;
    ctime = 56'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk(wp, 1'b1, "protect at reset");
    chk(cen, 1'b0, "charger at reset");
    wr1(8'h90, 8'hA5);
    rd1(8'h91, rb);
    chk(rb, 8'h00, "charger write under protect");
    wr1(8'h80, 8'h12);
    chk(wr_cnt, 0, "time load under protect");
    wr1(8'h8E, 8'h00);
    chk(wp, 1'b0, "protect cleared");
    wr1(8'h80, 8'h12);
    chk({wr_cnt[6:0], lmask, ldata[7:0]}, {7'h01, 7'h01, 8'h12}, "single load");
    $display("test protect done");
    for (int i = 0; i < 10; i++) begin
      wr1(8'h90, cv[i]);
      rd1(8'h91, rb);
      chk(rb, cv[i], "charger readback");
      chk({cen, ctwo, cres}, chg_exp(cv[i]), "decode");
    end
    $display("test charger done");
    cburst(64'h0007_0605_0403_0201);
    chk(wr_cnt, 2, "burst load count");
    chk({lmask, ldata}, {7'h7F, 56'h0706_0504_0302_01}, "burst load");
    @(posedge sys_clk);
    ctime <= tm;
    i_host.open_frame();
    i_host.put(8'hBF);
    i_host.get(rd[0]);
    @(posedge sys_clk);
    ctime <= 56'h0;
    // keep link edges off the block clock edge
    #13;
    for (int i = 1; i < 9; i++)
      i_host.get(rd[i]);
    i_host.close_frame();
    for (int i = 0; i < 9; i++)
      chk(rd[i], (i == 7) ? 8'h00 : tm[8*(i%8)+:8], "clock burst read");
    // single time read takes the live time at command end
    @(posedge sys_clk);
    ctime <= tm;
    #13;
    rd1(8'h85, rb);
    chk(rb, tm[23:16], "single time read");
    $display("test clock burst done");
    i_host.open_frame();
    i_host.put(8'hFE);
    for (int i = 0; i < 31; i++) begin
      mem[i] = 8'(i * 9 + 5);
      i_host.put(mem[i]);
    end
    i_host.close_frame();
    rd1(8'hC1, rb);
    chk(rb, mem[0], "ram first");
    rd1(8'hFD, rb);
    chk(rb, mem[30], "ram last");
    mem[1] = 8'h3C;
    wr1(8'hC2, mem[1]);
    rd1(8'hC3, rb);
    chk(rb, mem[1], "ram single write");
    wr1(8'h40, 8'hEE);
    rd1(8'hC1, rb);
    chk(rb, mem[0], "command without valid bit");
    i_host.open_frame();
    i_host.put(8'hFF);
    for (int i = 0; i < 31; i++) begin
      i_host.get(rb);
      chk(rb, mem[i], "ram burst read");
    end
    i_host.close_frame();
    $display("test ram done");
    wr1(8'h8E, 8'h80);
    cburst(64'h0);
    chk({wr_cnt[6:0], wp}, {7'h02, 1'b1}, "protected burst");
    wr1(8'hC2, 8'h00);
    rd1(8'hC3, rb);
    chk(rb, mem[1], "ram write under protect");
    $display("test protected burst done");
    conclude();
  end
endmodule
bind rtcb_top rtcb_checker i_chk (.sys_clk(sys_clk), .rstn(rstn), .link_sclk(link_sclk),
  .link_dio_oe(link_dio_oe), .core_wr_en(core_wr_en), .core_wr_mask(core_wr_mask),
  .write_protect(write_protect), .charger_enable(charger_enable),
  .charger_two_diodes(charger_two_diodes), .charger_resistor(charger_resistor));
